// >>> pkg/dea_defs.svh
// register offsets, field positions, reset values and counts of the dma end/arbitration core
// assumes a byte-addressed register port with 8-bit addresses
`ifndef DEA_DEFS_SVH
`define DEA_DEFS_SVH

// ====================================================================
// register map (channel n sits at n * stride)
`define DEA_CH_STRIDE 8'h10
`define DEA_OFF_MODE 4'h0
`define DEA_OFF_ACTL 4'h4
`define DEA_OFF_CNT 4'h8
`define DEA_OFF_CPUPRI 8'h40
`define DEA_OFF_BUSCTL2 8'h44
`define DEA_OFF_STATUS 8'h48

// ====================================================================
// channel_mode_reg fields
`define DEA_M_XEN 0
`define DEA_M_TEF 1
`define DEA_M_TEIE 2
`define DEA_M_ESF 3
`define DEA_M_ESCAPE_IRQ_ENABLE 4
`define DEA_M_SZE 5
`define DEA_M_DUAL 6
`define DEA_M_AUTO 10
`define DEA_M_BURST 11
`define DEA_M_ERR 31
`define DEA_M_XMODE_LO 8
`define DEA_M_PRIO_LO 12
`define DEA_M_ASIZE_LO 16
`define DEA_MODE_WMASK 32'h8003_7FFF
`define DEA_XMODE_NORMAL 2'h0
`define DEA_XMODE_REPEAT 2'h1
`define DEA_XMODE_BLOCK 2'h2

// ====================================================================
// address_control_reg fields
`define DEA_A_RPTE 0
`define DEA_A_SARE 1
`define DEA_A_DARE 2
`define DEA_A_RSIZE_LO 8
`define DEA_A_BSIZE_LO 16
`define DEA_ACTL_WMASK 32'h00FF_FF07

// ====================================================================
// cpu_priority_ctrl_reg and bus_control_reg_two fields
`define DEA_C_EN 7
`define DEA_B_IARB 0

// ====================================================================
// reset values
`define DEA_MODE_RST 32'h0000_0000
`define DEA_ACTL_RST 32'h0000_0000
`define DEA_CNT_RST 16'h0000
`define DEA_CPUPRI_RST 8'h00
`define DEA_BUSCTL2_RST 1'b0

`endif

// >>> pkg/dea_pkg.sv
// types shared by the dma end/arbitration core and its helpers
// assumes dea_defs.svh for all numeric constants
package dea_pkg;

  // ==================================================================
  // sequencer states
  typedef enum logic [2:0] {
    DEA_ST_IDLE,
    DEA_ST_READ,
    DEA_ST_WRITE,
    DEA_ST_SINGLE,
    DEA_ST_HOLD,
    DEA_ST_GAP
  } dea_state_t;

  typedef logic [3:0] dea_chvec_t;
  typedef logic [3:0][2:0] dea_prio_t;

endpackage : dea_pkg

// >>> pkg/dea_if.sv
// internal carrier between the core, the channel arbiter and the interrupt stage
// assumes all three sit on one clock
interface dea_if;
  import dea_pkg::*;

  // arbitration group
  dea_chvec_t eligible;
  dea_prio_t ch_prio;
  logic [2:0] cpu_level;
  logic cpu_ctl_en;
  logic sel_valid;
  logic [1:0] sel_ch;

  // interrupt group
  dea_chvec_t te_flag;
  dea_chvec_t te_en;
  dea_chvec_t es_flag;
  dea_chvec_t es_en;

  modport core_mp (output eligible, ch_prio, cpu_level, cpu_ctl_en, te_flag, te_en, es_flag,
                   es_en, input sel_valid, sel_ch);
  modport arb_mp (input eligible, ch_prio, cpu_level, cpu_ctl_en, output sel_valid, sel_ch);
  modport irq_mp (input te_flag, te_en, es_flag, es_en);
endinterface : dea_if

// >>> src/dea_arb.sv
// channel selection with cpu priority masking
// assumes eligible already folds in enable and pending request
module dea_arb (
  // carrier
  dea_if.arb_mp bus
);
  import dea_pkg::*;

  // ==================================================================
  // mask then pick highest level, lowest index on a tie
  always_comb begin
    logic [2:0] best;
    best = 3'h0;
    bus.sel_valid = 1'b0;
    bus.sel_ch = 2'h0;
    for (int i = 0; i < 4; i++) begin
      // a masked request stays pending in the core, it only loses this round
      if (bus.eligible[i] && !(bus.cpu_ctl_en && (bus.cpu_level > bus.ch_prio[i])) &&
          (!bus.sel_valid || bus.ch_prio[i] > best)) begin
        bus.sel_valid = 1'b1;
        bus.sel_ch = i[1:0];
        best = bus.ch_prio[i];
      end
    end
  end

endmodule : dea_arb

// >>> src/dea_irq.sv
// per-channel interrupt requests and fixed-priority summary
// assumes flags come straight from the channel registers and enables from them masked by standby
module dea_irq (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // carrier
  dea_if.irq_mp bus,
  // requests
  output logic [3:0] count_end_irq_q,
  output logic [3:0] escape_end_irq_q,
  output logic irq_any_q,
  output logic [2:0] irq_id_q
);
  import dea_pkg::*;

  logic [7:0] req;

  // ==================================================================
  // each request is flag and enable; index 0..3 count end, 4..7 escape
  assign req = {bus.es_flag & bus.es_en, bus.te_flag & bus.te_en};

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      count_end_irq_q <= 4'h0;
      escape_end_irq_q <= 4'h0;
    end else begin
      count_end_irq_q <= req[3:0];
      escape_end_irq_q <= req[7:4];
    end
  end

  // lowest index wins: count end 0..3 before escape 0..3
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq_any_q <= 1'b0;
      irq_id_q <= 3'h0;
    end else begin
      irq_any_q <= |req;
      irq_id_q <= 3'h0;
      for (int k = 7; k >= 0; k--) begin
        if (req[k]) irq_id_q <= k[2:0];
      end
    end
  end

endmodule : dea_irq

// >>> src/dea_top.sv
// four-channel dma termination, bus sharing and interrupt core
// assumes a bus controller that answers each access with one acc_done pulse
`include "dea_defs.svh"

// How it works
// - dual normal/repeat stop finishes the write
// - single normal/repeat stop finishes current access
// - block stop mid-block, pending write still done
// - address error clears enables, sets error flag
// - reset or standby initialises everything
// - cpu above channel level masks its requests
// - channel at or above cpu level proceeds
// - masked requests wait, dropped with enable
// - no bus release between read and write
// - block and auto-request burst run back to back
// - cycle stealing alternates with on-chip masters
// - arbitration enable alternates outside read/write pairs
// - refresh or bus release pauses burst/block
// - dual mode releases bus only after write
// - fixed interrupt order count end then escape
// - request is flag and its enable
// - four escape causes share one request
// - count reaching zero sets count end flag when its interrupt enable is set
// - enabled escape cause sets escape flag
// - size error when count below unit
// - repeat group end raises repeat end
// - nmi clears enables, sets error flag, stops
// - escape end clears enable, sets escape flag
module dea_top (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic standby,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata_q,
  // requests and stop sources
  input wire dea_pkg::dea_chvec_t ch_req,
  input wire logic nmi,
  input wire logic addr_err,
  input wire dea_pkg::dea_chvec_t src_area_ovf,
  input wire dea_pkg::dea_chvec_t dst_area_ovf,
  // bus controller side
  output logic acc_start_q,
  output logic acc_write_q,
  output logic [1:0] acc_ch_q,
  output logic [2:0] acc_bytes_q,
  input wire logic acc_done,
  input wire logic refresh_req,
  input wire logic ext_release_req,
  input wire logic master_req,
  output logic bus_release_q,
  // interrupt controller side
  output logic [3:0] count_end_irq_q,
  output logic [3:0] escape_end_irq_q,
  output logic irq_any_q,
  output logic [2:0] irq_id_q
);
  import dea_pkg::*;

  // ==================================================================
  // state
  logic [31:0] mode_q [4];
  logic [31:0] actl_q [4];
  logic [15:0] cnt_q [4];
  logic [7:0] rep_left_q [4];
  dea_chvec_t rep_done_q;
  dea_chvec_t pend_q;
  logic [7:0] cpupri_q;
  logic iarb_q;
  logic err_q;
  dea_state_t state_q, state_d;
  logic [1:0] ch_q, ch_d;
  logic [7:0] blk_left_q, blk_left_d;
  logic stop_q;
  logic ovf_q;

  // per-channel events from the sequencer
  dea_chvec_t ev_clr_en, ev_te, ev_es, ev_unit, ev_accept, ev_rep_reload;
  logic launch, launch_wr, forced;
  logic [2:0] bytes_d;

  dea_if link ();

  // ==================================================================
  // helpers on the channel being looked at
  function automatic logic [2:0] unit_bytes(input logic [1:0] asz);
    unit_bytes = (asz == 2'h0) ? 3'h1 : (asz == 2'h1) ? 3'h2 : 3'h4;
  endfunction : unit_bytes

  logic [1:0] cand;
  logic resume;
  logic [31:0] cm, ca;
  logic [15:0] cc;
  logic [1:0] cxm;
  logic [2:0] cab;
  logic [15:0] cneed;
  logic hold_req;

  // resume a block in flight before taking a new arbitration result
  assign resume = (blk_left_q != 8'h00) && mode_q[ch_q][`DEA_M_XEN];
  assign cand = resume ? ch_q : link.sel_ch;
  assign cm = (state_q == DEA_ST_IDLE) ? mode_q[cand] : mode_q[ch_q];
  assign ca = (state_q == DEA_ST_IDLE) ? actl_q[cand] : actl_q[ch_q];
  assign cc = (state_q == DEA_ST_IDLE) ? cnt_q[cand] : cnt_q[ch_q];
  assign cxm = cm[`DEA_M_XMODE_LO +: 2];
  assign cab = unit_bytes(cm[`DEA_M_ASIZE_LO +: 2]);
  // in block mode the whole block is the unit that must fit in the count
  assign cneed = (cxm == `DEA_XMODE_BLOCK) ?
                 16'(ca[`DEA_A_BSIZE_LO +: 8]) * 16'(cab) : {13'h0000, cab};
  assign hold_req = refresh_req | ext_release_req;
  assign forced = nmi | addr_err;

  // ==================================================================
  // sequencer next state and per-channel events
  always_comb begin
    logic [15:0] left;
    logic blk_last;
    state_d = state_q;
    ch_d = ch_q;
    blk_left_d = blk_left_q;
    ev_clr_en = 4'h0;
    ev_te = 4'h0;
    ev_es = 4'h0;
    ev_unit = 4'h0;
    ev_accept = 4'h0;
    ev_rep_reload = 4'h0;
    launch = 1'b0;
    launch_wr = 1'b0;
    // short remainder without size error checking moves in bytes
    bytes_d = ({13'h0000, cab} > cc && cc != 16'h0000) ? 3'h1 : cab;
    left = cc - 16'(bytes_d);
    blk_last = (blk_left_q <= 8'h01);
    case (state_q)
      DEA_ST_IDLE: begin
        if (hold_req) begin
          state_d = DEA_ST_HOLD;
        end else if (!forced && (resume || link.sel_valid)) begin
          ch_d = cand;
          if (!resume) ev_accept[cand] = 1'b1;
          if (cc < cneed && cm[`DEA_M_SZE] && !resume) begin
            ev_es[cand] = 1'b1;
          end else if (cxm == `DEA_XMODE_REPEAT && rep_done_q[cand]) begin
            ev_rep_reload[cand] = 1'b1;
            ev_es[cand] = ca[`DEA_A_RPTE];
          end else begin
            launch = 1'b1;
            if (!resume && cxm == `DEA_XMODE_BLOCK) blk_left_d = ca[`DEA_A_BSIZE_LO +: 8];
            state_d = cm[`DEA_M_DUAL] ? DEA_ST_READ : DEA_ST_SINGLE;
          end
        end
        if (forced) blk_left_d = 8'h00;
      end
      DEA_ST_READ: begin
        // the write that matches a finished read always follows, stop or not
        if (acc_done) begin
          launch = 1'b1;
          launch_wr = 1'b1;
          state_d = DEA_ST_WRITE;
        end
      end
      DEA_ST_WRITE, DEA_ST_SINGLE: begin
        if (acc_done) begin
          ev_unit[ch_q] = 1'b1;
          if (cxm == `DEA_XMODE_BLOCK) blk_left_d = blk_last ? 8'h00 : blk_left_q - 8'h01;
          state_d = DEA_ST_IDLE;
          if (left == 16'h0000 && cc != 16'h0000) begin
            ev_clr_en[ch_q] = 1'b1;
            ev_te[ch_q] = cm[`DEA_M_TEIE];
            blk_left_d = 8'h00;
          end else if (stop_q || forced) begin
            blk_left_d = 8'h00;
          end else if (ovf_q && (cxm != `DEA_XMODE_BLOCK || blk_last)) begin
            ev_es[ch_q] = 1'b1;
            blk_left_d = 8'h00;
          end else if (hold_req) begin
            // only reached after a write or single access, never mid pair
            state_d = DEA_ST_HOLD;
          end else if ((cxm == `DEA_XMODE_BLOCK && !blk_last) ||
                       (cm[`DEA_M_BURST] && cm[`DEA_M_AUTO] && cm[`DEA_M_XEN])) begin
            // back to back unless the arbitration enable lets masters in
            if (iarb_q && master_req) begin
              state_d = DEA_ST_GAP;
            end else begin
              launch = 1'b1;
              state_d = cm[`DEA_M_DUAL] ? DEA_ST_READ : DEA_ST_SINGLE;
            end
          end else if (master_req) begin
            state_d = DEA_ST_GAP;
          end
        end
      end
      DEA_ST_HOLD: if (!hold_req) state_d = DEA_ST_IDLE;
      DEA_ST_GAP: state_d = DEA_ST_IDLE;
      default: state_d = DEA_ST_IDLE;
    endcase
    // an escape or count end mid-pair is never raised here; they sit at unit end or in idle
    ev_clr_en = ev_clr_en | ev_es;
  end

  // ==================================================================
  // sequencer registers; standby clears like reset
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= DEA_ST_IDLE;
      ch_q <= 2'h0;
      blk_left_q <= 8'h00;
    end else if (standby) begin
      state_q <= DEA_ST_IDLE;
      ch_q <= 2'h0;
      blk_left_q <= 8'h00;
    end else begin
      state_q <= state_d;
      ch_q <= ch_d;
      blk_left_q <= blk_left_d;
    end
  end

  // forced stop and area overflow are held until the unit ends
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stop_q <= 1'b0;
      ovf_q <= 1'b0;
    end else if (standby || state_d == DEA_ST_IDLE || state_d == DEA_ST_HOLD) begin
      stop_q <= 1'b0;
      ovf_q <= 1'b0;
    end else begin
      stop_q <= stop_q | forced | !mode_q[ch_q][`DEA_M_XEN];
      ovf_q <= ovf_q | (src_area_ovf[ch_q] & actl_q[ch_q][`DEA_A_SARE]) |
               (dst_area_ovf[ch_q] & actl_q[ch_q][`DEA_A_DARE]);
    end
  end

  // access strobe to the bus controller and bus release
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      acc_start_q <= 1'b0;
      acc_write_q <= 1'b0;
      acc_ch_q <= 2'h0;
      acc_bytes_q <= 3'h0;
      bus_release_q <= 1'b0;
    end else if (standby) begin
      acc_start_q <= 1'b0;
      acc_write_q <= 1'b0;
      acc_ch_q <= 2'h0;
      acc_bytes_q <= 3'h0;
      bus_release_q <= 1'b0;
    end else begin
      acc_start_q <= launch;
      if (launch) begin
        acc_write_q <= launch_wr;
        acc_ch_q <= ch_d;
        acc_bytes_q <= bytes_d;
      end
      bus_release_q <= (state_d == DEA_ST_HOLD) || (state_d == DEA_ST_GAP);
    end
  end

  // ==================================================================
  // global registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cpupri_q <= `DEA_CPUPRI_RST;
      iarb_q <= `DEA_BUSCTL2_RST;
      err_q <= 1'b0;
    end else if (standby) begin
      cpupri_q <= `DEA_CPUPRI_RST;
      iarb_q <= `DEA_BUSCTL2_RST;
      err_q <= 1'b0;
    end else begin
      if (reg_wr && reg_addr == `DEA_OFF_CPUPRI) cpupri_q <= reg_wdata[7:0];
      if (reg_wr && reg_addr == `DEA_OFF_BUSCTL2) iarb_q <= reg_wdata[`DEA_B_IARB];
      // set wins over a write of zero in the same cycle
      if (forced) err_q <= 1'b1;
      else if (reg_wr && reg_addr == `DEA_OFF_MODE) err_q <= reg_wdata[`DEA_M_ERR];
    end
  end

  // ==================================================================
  // per-channel registers
  for (genvar i = 0; i < 4; i++) begin : g_ch
    logic hit_m, hit_a, hit_c, en_wr;
    assign hit_m = reg_wr && reg_addr == (8'(i) * `DEA_CH_STRIDE + 8'(`DEA_OFF_MODE));
    assign hit_a = reg_wr && reg_addr == (8'(i) * `DEA_CH_STRIDE + 8'(`DEA_OFF_ACTL));
    assign hit_c = reg_wr && reg_addr == (8'(i) * `DEA_CH_STRIDE + 8'(`DEA_OFF_CNT));
    // enable may not be set again while the error flag is up
    assign en_wr = reg_wdata[`DEA_M_XEN] && !err_q;

    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        mode_q[i] <= `DEA_MODE_RST;
        actl_q[i] <= `DEA_ACTL_RST;
        cnt_q[i] <= `DEA_CNT_RST;
      end else if (standby) begin
        mode_q[i] <= `DEA_MODE_RST;
        actl_q[i] <= `DEA_ACTL_RST;
        cnt_q[i] <= `DEA_CNT_RST;
      end else begin
        if (hit_m) begin
          mode_q[i][30:5] <= reg_wdata[30:5] & 26'(`DEA_MODE_WMASK >> 5);
          mode_q[i][`DEA_M_TEIE] <= reg_wdata[`DEA_M_TEIE];
          mode_q[i][`DEA_M_ESCAPE_IRQ_ENABLE] <= reg_wdata[`DEA_M_ESCAPE_IRQ_ENABLE];
        end
        mode_q[i][`DEA_M_XEN] <= !(forced || ev_clr_en[i]) &&
                                 (hit_m ? en_wr : mode_q[i][`DEA_M_XEN]);
        // flags: zero written clears, hardware set wins the same cycle
        mode_q[i][`DEA_M_TEF] <= ev_te[i] ||
                                 (mode_q[i][`DEA_M_TEF] && !(hit_m && !reg_wdata[`DEA_M_TEF]));
        mode_q[i][`DEA_M_ESF] <= ev_es[i] ||
                                 (mode_q[i][`DEA_M_ESF] && !(hit_m && !reg_wdata[`DEA_M_ESF]));
        mode_q[i][`DEA_M_ERR] <= 1'b0;
        if (hit_a) actl_q[i] <= reg_wdata & `DEA_ACTL_WMASK;
        if (ev_unit[i]) cnt_q[i] <= cnt_q[i] - 16'(acc_bytes_q);
        else if (hit_c) cnt_q[i] <= reg_wdata[15:0];
      end
    end

    // repeat group tracking and pending requests
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        rep_left_q[i] <= 8'h00;
        rep_done_q[i] <= 1'b0;
        pend_q[i] <= 1'b0;
      end else if (standby) begin
        rep_left_q[i] <= 8'h00;
        rep_done_q[i] <= 1'b0;
        pend_q[i] <= 1'b0;
      end else begin
        if (hit_a || ev_rep_reload[i] || !mode_q[i][`DEA_M_XEN]) begin
          rep_left_q[i] <= hit_a ? reg_wdata[`DEA_A_RSIZE_LO +: 8] :
                           actl_q[i][`DEA_A_RSIZE_LO +: 8];
          rep_done_q[i] <= 1'b0;
        end else if (ev_unit[i] && mode_q[i][`DEA_M_XMODE_LO +: 2] == `DEA_XMODE_REPEAT) begin
          rep_left_q[i] <= rep_left_q[i] - 8'h01;
          rep_done_q[i] <= (rep_left_q[i] <= 8'h01);
        end
        // a masked request waits here until taken or enable drops
        pend_q[i] <= mode_q[i][`DEA_M_XEN] && ((pend_q[i] && !ev_accept[i]) || ch_req[i]);
      end
    end

    assign link.eligible[i] = mode_q[i][`DEA_M_XEN] && (pend_q[i] || mode_q[i][`DEA_M_AUTO]);
    assign link.ch_prio[i] = mode_q[i][`DEA_M_PRIO_LO +: 3];
    assign link.te_flag[i] = mode_q[i][`DEA_M_TEF];
    assign link.te_en[i] = mode_q[i][`DEA_M_TEIE] && !standby;
    assign link.es_flag[i] = mode_q[i][`DEA_M_ESF];
    assign link.es_en[i] = mode_q[i][`DEA_M_ESCAPE_IRQ_ENABLE] && !standby;
  end

  assign link.cpu_level = cpupri_q[2:0];
  assign link.cpu_ctl_en = cpupri_q[`DEA_C_EN];

  // ==================================================================
  // read data, one cycle after the strobe; unmapped reads as zero
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reg_rdata_q <= 32'h0000_0000;
    end else begin
      reg_rdata_q <= 32'h0000_0000;
      if (reg_rd) begin
        if (reg_addr < 8'h40) begin
          case (reg_addr[3:0])
            `DEA_OFF_MODE: reg_rdata_q <= mode_q[reg_addr[5:4]] |
                                          ((reg_addr[5:4] == 2'h0) ? {err_q, 31'h0} : 32'h0);
            `DEA_OFF_ACTL: reg_rdata_q <= actl_q[reg_addr[5:4]];
            `DEA_OFF_CNT: reg_rdata_q <= {16'h0000, cnt_q[reg_addr[5:4]]};
            default: reg_rdata_q <= 32'h0000_0000;
          endcase
        end else if (reg_addr == `DEA_OFF_CPUPRI) begin
          reg_rdata_q <= {24'h000000, cpupri_q};
        end else if (reg_addr == `DEA_OFF_BUSCTL2) begin
          reg_rdata_q <= {31'h0, iarb_q};
        end else if (reg_addr == `DEA_OFF_STATUS) begin
          reg_rdata_q <= {16'h0000, blk_left_q, stop_q, ch_q, 2'h0, state_q};
        end
      end
    end
  end

  // ==================================================================
  // helpers
  dea_arb u_arb (
    .bus(link.arb_mp)
  );

  dea_irq u_irq (
    .clk(clk),
    .rst(rst),
    .bus(link.irq_mp),
    .count_end_irq_q(count_end_irq_q),
    .escape_end_irq_q(escape_end_irq_q),
    .irq_any_q(irq_any_q),
    .irq_id_q(irq_id_q)
  );

endmodule : dea_top

// >>> verif/dea_bsc_model.sv
// bus controller stand-in: one done pulse per access start
// assumes lat is set by the bench between accesses, 1 = prompt, 3 = slow
module dea_bsc_model (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // access link
  input wire logic acc_start_q,
  input wire logic [1:0] lat,
  output logic acc_done
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] cnt_q;
  // ====================
  // one access at a time
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q <= 2'h0;
      acc_done <= 1'b0;
    end else begin
      acc_done <= (cnt_q == 2'h1);
      if (acc_start_q) begin
        cnt_q <= lat;
      end else if (cnt_q != 2'h0) begin
        cnt_q <= cnt_q - 2'h1;
      end
    end
  end
endmodule : dea_bsc_model

// >>> verif/dea_props.sv
// port-level checks of the dma end/arbitration core
// assumes one clock domain, reset rst active high
module dea_props (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic standby,
  // stops and bus side
  input wire logic nmi,
  input wire logic addr_err,
  input wire logic refresh_req,
  input wire logic acc_done,
  input wire logic acc_start_q,
  input wire logic acc_write_q,
  input wire logic bus_release_q,
  // interrupts
  input wire logic [3:0] count_end_irq_q,
  input wire logic [3:0] escape_end_irq_q,
  input wire logic irq_any_q,
  input wire logic [2:0] irq_id_q
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // ====================
  // pairs stay glued; stops and holds block launches
  property p_rw_pair;
    acc_start_q && acc_write_q |-> $past(acc_done) && !$past(bus_release_q);
  endproperty
  a_rw_pair: assert property (p_rw_pair) else $error("split pair");
  property p_no_start_released;
    acc_start_q |-> !bus_release_q;
  endproperty
  a_no_start_released: assert property (p_no_start_released) else $error("start while released");
  property p_refresh_hold;
    refresh_req && bus_release_q |=> !acc_start_q;
  endproperty
  a_refresh_hold: assert property (p_refresh_hold) else $error("start during refresh");
  property p_nmi_stop;
    nmi |=> !(acc_start_q && !acc_write_q);
  endproperty
  a_nmi_stop: assert property (p_nmi_stop) else $error("launch after nmi");
  property p_aerr_stop;
    addr_err |=> !(acc_start_q && !acc_write_q);
  endproperty
  a_aerr_stop: assert property (p_aerr_stop) else $error("launch after address error");
  property p_standby_init;
    standby |=> !acc_start_q && !bus_release_q && !irq_any_q && count_end_irq_q == 4'h0;
  endproperty
  a_standby_init: assert property (p_standby_init) else $error("standby left state");
  // ====================
  // interrupt summary and order
  property p_any;
    irq_any_q == |{count_end_irq_q, escape_end_irq_q};
  endproperty
  a_any: assert property (p_any) else $error("summary mismatch");
  property p_id_top;
    count_end_irq_q[0] |-> irq_id_q == 3'h0;
  endproperty
  a_id_top: assert property (p_id_top) else $error("count end 0 not first");
  property p_id_esc;
    count_end_irq_q == 4'h0 && escape_end_irq_q[0] |-> irq_id_q == 3'h4;
  endproperty
  a_id_esc: assert property (p_id_esc) else $error("escape 0 order wrong");
  c_pair: cover property (acc_start_q && acc_write_q);
  c_rel: cover property (bus_release_q && refresh_req);
  c_esc: cover property (escape_end_irq_q[0]);
endmodule : dea_props

bind dea_top dea_props u_props (.clk, .rst, .standby, .nmi, .addr_err, .refresh_req,
  .acc_done, .acc_start_q, .acc_write_q, .bus_release_q, .count_end_irq_q,
  .escape_end_irq_q, .irq_any_q, .irq_id_q);

// >>> verif/tb_top.sv
// self-checking bench of the dma core
// assumes the offsets and fields of dea_defs.svh
`include "dea_defs.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] XEN = 32'h1 << `DEA_M_XEN, TEF = 32'h1 << `DEA_M_TEF,
    TEIE = 32'h1 << `DEA_M_TEIE, ESF = 32'h1 << `DEA_M_ESF, ESCAPE_IRQ_ENABLE = 32'h1 << `DEA_M_ESCAPE_IRQ_ENABLE,
    SZE = 32'h1 << `DEA_M_SZE, DUAL = 32'h1 << `DEA_M_DUAL, AUTO = 32'h1 << `DEA_M_AUTO;
  logic clk = 1'b0, rst = 1'b1, standby = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic nmi = 1'b0, addr_err = 1'b0, refresh_req = 1'b0, acc_done;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0, reg_rdata_q, d;
  logic [3:0] ch_req = 4'h0, cei, eei;
  logic [1:0] lat = 2'h1, ch;
  logic [2:0] bytes, irq_id;
  logic start, wr, rel, any;
  int failures = 0, cmp_count = 0, i, k;
  always #4 clk = ~clk;
  dea_top u_dut (.clk, .rst, .standby, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata_q, .ch_req, .nmi, .addr_err, .src_area_ovf(4'h0), .dst_area_ovf(4'h0),
    .acc_start_q(start), .acc_write_q(wr), .acc_ch_q(ch), .acc_bytes_q(bytes), .acc_done,
    .refresh_req, .ext_release_req(1'b0), .master_req(1'b0), .bus_release_q(rel),
    .count_end_irq_q(cei), .escape_end_irq_q(eei), .irq_any_q(any), .irq_id_q(irq_id));
  dea_bsc_model u_bsc (.clk, .rst, .acc_start_q(start), .lat, .acc_done);
  // ====================
  // port tasks; strobes last one cycle
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic wreg(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= v;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wreg
  task automatic rreg(input logic [7:0] a);
    @(posedge clk);
    reg_rd <= 1'b1; reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata_q;
  endtask : rreg
  // bounded wait for a selected request
  task automatic wait_irq(input logic [7:0] m);
    for (i = 0; i < 600 && ({eei, cei} & m) == 8'h0; i++) @(posedge clk);
    #1;
  endtask : wait_irq
  task automatic close_out;
    $display("checks %0d failures %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : close_out
  // watchdog: a run needs about 200 cycles
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    close_out;
  end
  // ====================
  // test sequence
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    rreg(`DEA_OFF_MODE); chk(d, `DEA_MODE_RST);
    rreg(8'hFC); chk(d, 32'h0);
    $display("reset test done");
    // two single byte units on channel 0
    wreg(`DEA_OFF_CNT, 32'h2);
    wreg(`DEA_OFF_MODE, XEN | TEIE);
    ch_req <= 4'h1;
    wait_irq(8'h01); chk({any, eei, cei, 1'b0, irq_id}, {1'b1, 8'h01, 4'h0});
    ch_req <= 4'h0;
    rreg(`DEA_OFF_MODE); chk(d, TEF | TEIE);
    wreg(`DEA_OFF_MODE, TEIE);
    @(posedge clk); #1 chk(cei, 4'h0);
    $display("count end test done");
    // size error: one byte left, word access
    wreg(`DEA_OFF_CNT, 32'h1);
    wreg(`DEA_OFF_MODE, XEN | AUTO | SZE | ESCAPE_IRQ_ENABLE | 32'h0001_0000);
    wait_irq(8'h10); chk({eei, 1'b0, irq_id}, {4'h1, 4'h4});
    rreg(`DEA_OFF_MODE); chk(d, ESF | AUTO | SZE | ESCAPE_IRQ_ENABLE | 32'h0001_0000);
    wreg(`DEA_OFF_MODE, 32'h0);
    @(posedge clk); #1 chk(eei, 4'h0);
    $display("size error test done");
    // dual longword on channel 1 after a refresh
    refresh_req <= 1'b1; lat <= 2'h3;
    wreg(8'h18, 32'h4);
    wreg(8'h10, XEN | TEIE | DUAL | AUTO | 32'h0002_0000);
    repeat (3) @(posedge clk);
    #1 chk(rel, 1'b1);
    refresh_req <= 1'b0;
    wait_irq(8'h02); chk({cei, 1'b0, irq_id, ch, bytes}, {4'h2, 4'h1, 2'h1, 3'h4});
    rreg(8'h10); chk(d, TEF | TEIE | DUAL | AUTO | 32'h0002_0000);
    $display("dual test done");
    // cpu level 5 masks level 4, level 4 passes
    wreg(`DEA_OFF_CPUPRI, 32'h85);
    wreg(8'h38, 32'h1);
    wreg(8'h30, XEN | AUTO | 32'h4000);
    repeat (20) @(posedge clk);
    rreg(8'h30); chk(d, XEN | AUTO | 32'h4000);
    wreg(`DEA_OFF_CPUPRI, 32'h84);
    repeat (20) @(posedge clk);
    rreg(8'h30); chk(d, AUTO | 32'h4000);
    wreg(`DEA_OFF_CPUPRI, 32'h0);
    $display("priority test done");
    // forced stops on channel 2: k=0 nmi, k=1 address error
    for (k = 0; k < 2; k++) begin
      wreg(`DEA_OFF_MODE, 32'h0);
      wreg(8'h28, 32'h40);
      wreg(8'h20, XEN | AUTO);
      repeat (10) @(posedge clk);
      nmi <= (k == 0); addr_err <= (k == 1);
      @(posedge clk);
      nmi <= 1'b0; addr_err <= 1'b0;
      repeat (6) @(posedge clk);
      rreg(8'h20); chk(d, AUTO);
      rreg(`DEA_OFF_MODE); chk(d[`DEA_M_ERR], 1'b1);
      wreg(8'h20, XEN | AUTO);
      rreg(8'h20); chk(d, AUTO);
    end
    $display("forced stop test done");
    // standby wipes error flag and channels
    standby <= 1'b1;
    @(posedge clk);
    standby <= 1'b0;
    rreg(`DEA_OFF_MODE); chk(d, `DEA_MODE_RST);
    rreg(8'h10); chk(d, `DEA_MODE_RST);
    $display("standby test done");
    close_out;
  end
endmodule : tb_top
